// ### rtl/srctl_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Setpoint: one mantissa digit, signed two-digit exponent
// - Span one e-12 up to nine e+5
// - Compare raw display words, no unit conversion
// - Above-atmosphere setpoint always active except overflow
// - Below minimum is zero: always inactive
// - Button tap shows setpoint two seconds
// - Held buttons scroll, slow then fast
// - Two seconds after release, store to nonvolatile
// - Both ion gauges off: channels 1-2 off
// - Missing secondary modules keep channels 3-6 off
// - Degas freezes ion channel pressure
// - Ten percent hysteresis above setpoint
// - Round hysteresis up at half digit
// - Ignore bus data while setpoint shown
// - Selector change waits for next press from idle, after the display clears
// - Indicators show final relay state
// - Channel pairs follow their gauge lines
// - Ion channels selectable to either gauge
// - Per-channel polarity selection
// - Relay from automatic decision or override
// - Override right on, left off
// - Polarity off activates below setpoint
// - Inhibit switch forces channel 1-2 relay off while its gauge is on
module srctl_top
	import srctl_pkg::*;
#(
	parameter int unsigned SHOW_CYCLES = srctl_pkg::SHOW_CYC,
	parameter int unsigned SLOW_CYCLES = srctl_pkg::SLOW_CYC,
	parameter int unsigned FAST_CYCLES = srctl_pkg::FAST_CYC
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	// Wishbone slave
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// Front panel
	input wire logic UP_BTN_IN,
	input wire logic DOWN_BTN_IN,
	input wire logic [2:0] CHAN_SEL_IN,
	// Gauge status
	input wire logic FIRST_ION_GAUGE_ON_IN,
	input wire logic SECOND_ION_GAUGE_ON_IN,
	input wire logic DEGAS_IN,
	input wire logic SEC_A_PRESENT_IN,
	input wire logic SEC_B_PRESENT_IN,
	// Display bus
	input wire logic DISP_STB_IN,
	input wire logic [1:0] DISP_LINE_IN,
	input wire logic DISP_GAUGE_IN,
	input wire logic [3:0] DISP_D1_IN,
	input wire logic [3:0] DISP_D2_IN,
	input wire logic signed [5:0] DISP_EXP_IN,
	input wire logic DISP_OVF_IN,
	// Setpoint display
	output logic SP_SHOW_OUT,
	output logic [1:0] SP_LINE_OUT,
	output logic [3:0] SP_MANT_OUT,
	output logic signed [5:0] SP_EXP_OUT,
	// Nonvolatile storage write port
	output logic NVM_WR_OUT,
	output logic [2:0] NVM_ADDR_OUT,
	output logic [12:0] NVM_DATA_OUT,
	// Relays and indicators
	output logic [srctl_pkg::NCH-1:0] RELAY_OUT,
	output logic [srctl_pkg::NCH-1:0] LED_OUT
);
	import srctl_pkg::*;

	// ****************************************
	// Helper functions
	// ****************************************
	// Monotonic compare key: biased exponent then tenths of mantissa
	function automatic logic [12:0] key_of(input logic signed [5:0] e, input logic [6:0] m);
		int k;
		k = (int'(e) + EXP_BIAS) * 100 + int'(m);
		return 13'(k);
	endfunction

	// Release point: setpoint plus rounded tenth plus one digit
	function automatic logic [12:0] thr_of(input logic signed [5:0] e, input logic [3:0] d);
		int m;
		int t;
		m = int'(d) * 10;
		t = m + (m + 5) / 10 + 1;
		if (t > 99) begin
			return key_of(6'(e + 6'sd1), 7'(t / 10));
		end
		return key_of(e, 7'(t));
	endfunction

	// One scroll step: {decade crossed, mantissa, exponent}
	function automatic logic [10:0] step_of(input logic up, input logic [3:0] m,
			input logic signed [5:0] e);
		logic [10:0] r;
		r = {1'b0, m, e};
		if (up) begin
			if (m == MANT_ZERO) begin
				r = {1'b1, MANT_MIN, EXP_MIN};
			end else if (m == MANT_ATM) begin
				r = {1'b0, m, e};
			end else if (m < MANT_MAX) begin
				r = {1'b0, 4'(m + 4'h1), e};
			end else if (e == EXP_MAX) begin
				r = {1'b1, MANT_ATM, e};
			end else begin
				r = {1'b1, MANT_MIN, 6'(e + 6'sd1)};
			end
		end else begin
			if (m == MANT_ATM) begin
				r = {1'b1, MANT_MAX, EXP_MAX};
			end else if (m == MANT_ZERO) begin
				r = {1'b0, m, e};
			end else if (m > MANT_MIN) begin
				r = {1'b0, 4'(m - 4'h1), e};
			end else if (e == EXP_MIN) begin
				r = {1'b1, MANT_ZERO, e};
			end else begin
				r = {1'b1, MANT_MAX, 6'(e - 6'sd1)};
			end
		end
		return r;
	endfunction

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int SW = 29;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic stb_prev;

	// Every panel, gauge and display pin crosses two flops; bus data must stay stable around its strobe
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			sync1 <= '0;
			sync2 <= '0;
			stb_prev <= 1'b0;
		end else begin
			sync1 <= {UP_BTN_IN, DOWN_BTN_IN, CHAN_SEL_IN, FIRST_ION_GAUGE_ON_IN,
				SECOND_ION_GAUGE_ON_IN, DEGAS_IN, SEC_A_PRESENT_IN, SEC_B_PRESENT_IN,
				DISP_STB_IN, DISP_LINE_IN, DISP_GAUGE_IN, DISP_D1_IN, DISP_D2_IN,
				DISP_EXP_IN, DISP_OVF_IN};
			sync2 <= sync1;
			stb_prev <= sync2[18];
		end
	end

	logic up_btn;
	logic dn_btn;
	logic [2:0] chan_sel;
	logic [1:0] ig_on;
	logic degas;
	logic sec_a;
	logic sec_b;
	logic word_new;
	logic [1:0] w_line;
	logic w_gauge;
	logic [3:0] w_d1;
	logic [3:0] w_d2;
	logic signed [5:0] w_exp;
	logic w_ovf;
	logic [12:0] w_key;

	// Unpack the settled copy
	assign up_btn = sync2[28];
	assign dn_btn = sync2[27];
	assign chan_sel = sync2[26:24];
	assign ig_on = {sync2[22], sync2[23]};
	assign degas = sync2[21];
	assign sec_a = sync2[20];
	assign sec_b = sync2[19];
	assign word_new = sync2[18] & ~stb_prev;
	assign w_line = sync2[17:16];
	assign w_gauge = sync2[15];
	assign w_d1 = sync2[14:11];
	assign w_d2 = sync2[10:7];
	assign w_exp = sync2[6:1];
	assign w_ovf = sync2[0];
	// Pressure taken as printed, whatever the units switch says
	assign w_key = w_ovf ? KEY_OVF :
		(w_d1 == 4'h0) ? 13'h0000 : key_of(w_exp, 7'(w_d1 * 4'd10 + w_d2));

	// ****************************************
	// Wishbone slave and control registers
	// ****************************************
	logic [31:0] ctrl_reg;
	logic [31:0] ovr_reg;
	logic [3:0] sp_mant [NCH];
	logic signed [5:0] sp_exp [NCH];
	logic wb_req;
	logic wb_wr;
	logic [7:0] sp_off;
	logic [2:0] sp_idx;
	logic sp_hit;
	logic [31:0] rd_mux;
	logic [31:0] status;

	assign wb_req = WB_CYC_IN & WB_STB_IN;
	assign wb_wr = wb_req & WB_WE_IN & WB_ACK_OUT;
	assign sp_off = 8'(WB_ADR_IN - ADR_SP0);
	assign sp_idx = sp_off[4:2];
	// Upper offset bits checked too, so far addresses do not alias a setpoint
	assign sp_hit = (WB_ADR_IN >= ADR_SP0) && (sp_off[1:0] == 2'b00)
		&& (sp_off[7:5] == 3'b000) && (sp_idx < 3'(NCH));

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= '0;
		end else begin
			WB_ACK_OUT <= wb_req & ~WB_ACK_OUT;
			if (wb_req & ~WB_ACK_OUT) begin
				WB_DAT_OUT <= rd_mux;
			end
		end
	end

	// Read mux, unmapped reads as zero
	always_comb begin
		rd_mux = '0;
		if (WB_ADR_IN == ADR_CTRL) begin
			rd_mux = ctrl_reg;
		end else if (WB_ADR_IN == ADR_OVR) begin
			rd_mux = ovr_reg;
		end else if (WB_ADR_IN == ADR_STAT) begin
			rd_mux = status;
		end else if (sp_hit) begin
			rd_mux[3:0] = sp_mant[sp_idx];
			rd_mux[SP_EXP_LSB +: 6] = sp_exp[sp_idx];
		end
	end

	// Switch registers; unused bits stay zero
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			ctrl_reg <= CTRL_RST;
			ovr_reg <= OVR_RST;
		end else if (wb_wr) begin
			if (WB_ADR_IN == ADR_CTRL) begin
				ctrl_reg <= merge(ctrl_reg, WB_DAT_IN, WB_SEL_IN) & 32'h0000_0f3f;
			end
			if (WB_ADR_IN == ADR_OVR) begin
				ovr_reg <= merge(ovr_reg, WB_DAT_IN, WB_SEL_IN) & 32'h0000_3f3f;
			end
		end
	end

	logic [NCH-1:0] pol;
	logic [3:0] inh;
	logic [NCH-1:0] frc_on;
	logic [NCH-1:0] frc_off;
	assign pol = ctrl_reg[CTRL_POL_LSB +: NCH];
	assign inh = ctrl_reg[CTRL_INH_LSB +: 4];
	assign frc_on = ovr_reg[OVR_ON_LSB +: NCH];
	assign frc_off = ovr_reg[OVR_OFF_LSB +: NCH];

	// ****************************************
	// Setpoint display and adjustment
	// ****************************************
	srctl_ui_t ui;
	logic [TMR_W-1:0] tmr;
	logic fast;
	logic dirty;
	logic [2:0] ui_ch;
	logic any_btn;
	logic step_go;
	logic [10:0] step_res;

	assign any_btn = up_btn | dn_btn;
	assign step_go = (ui == SRCTL_HELD) && (tmr == '0);
	// Up wins if both are held
	assign step_res = step_of(up_btn, sp_mant[ui_ch], sp_exp[ui_ch]);

	// Panel sequencer: hold scrolls, release starts the show timeout
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			ui <= SRCTL_IDLE;
			tmr <= '0;
			fast <= 1'b0;
			dirty <= 1'b0;
			ui_ch <= 3'd0;
			NVM_WR_OUT <= 1'b0;
			NVM_ADDR_OUT <= 3'd0;
			NVM_DATA_OUT <= '0;
		end else begin
			NVM_WR_OUT <= 1'b0;
			case (ui)
				SRCTL_IDLE: begin
					// Selector only sampled here, so changes wait for a press after the show ends
					if (any_btn && chan_sel >= 3'd1 && chan_sel <= 3'(NCH)) begin
						ui <= SRCTL_HELD;
						ui_ch <= 3'(chan_sel - 3'd1);
						tmr <= TMR_W'(SLOW_CYCLES - 1);
						fast <= 1'b0;
						dirty <= 1'b0;
					end
				end
				SRCTL_HELD: begin
					if (!any_btn) begin
						ui <= SRCTL_SHOW;
						tmr <= TMR_W'(SHOW_CYCLES - 1);
					end else if (tmr == '0) begin
						dirty <= 1'b1;
						fast <= fast | step_res[10];
						tmr <= TMR_W'(((fast | step_res[10]) ? FAST_CYCLES : SLOW_CYCLES) - 1);
					end else begin
						tmr <= tmr - 1'b1;
					end
				end
				SRCTL_SHOW: begin
					if (any_btn) begin
						ui <= SRCTL_HELD;
						tmr <= TMR_W'(SLOW_CYCLES - 1);
						fast <= 1'b0;
					end else if (tmr == '0) begin
						ui <= SRCTL_IDLE;
						// Storage is written only on the way out, to spare its write life
						if (dirty) begin
							NVM_WR_OUT <= 1'b1;
							NVM_ADDR_OUT <= ui_ch;
							NVM_DATA_OUT <= {sp_mant[ui_ch], sp_exp[ui_ch][5],
								4'(((sp_exp[ui_ch] < 0) ? -sp_exp[ui_ch] : sp_exp[ui_ch]) / 10),
								4'(((sp_exp[ui_ch] < 0) ? -sp_exp[ui_ch] : sp_exp[ui_ch]) % 10)};
						end
					end else begin
						tmr <= tmr - 1'b1;
					end
				end
				default: ui <= SRCTL_IDLE;
			endcase
		end
	end

	// Setpoint store; a bus write wins over a scroll step
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			for (int i = 0; i < NCH; i++) begin
				sp_mant[i] <= SP_MANT_RST;
				sp_exp[i] <= SP_EXP_RST;
			end
		end else if (wb_wr && sp_hit && WB_SEL_IN[0] && WB_DAT_IN[3:0] <= MANT_ATM) begin
			sp_mant[sp_idx] <= WB_DAT_IN[3:0];
			if (WB_SEL_IN[1]) begin
				sp_exp[sp_idx] <= WB_DAT_IN[SP_EXP_LSB +: 6];
			end
		end else if (step_go) begin
			sp_mant[ui_ch] <= step_res[9:6];
			sp_exp[ui_ch] <= step_res[5:0];
		end
	end

	// Display drive, channel pairs share a line
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			SP_SHOW_OUT <= 1'b0;
			SP_LINE_OUT <= 2'd0;
			SP_MANT_OUT <= '0;
			SP_EXP_OUT <= '0;
		end else begin
			SP_SHOW_OUT <= (ui != SRCTL_IDLE);
			SP_LINE_OUT <= 2'(ui_ch[2:1] + 2'd1);
			SP_MANT_OUT <= sp_mant[ui_ch];
			SP_EXP_OUT <= sp_exp[ui_ch];
		end
	end

	// ****************************************
	// Pressure capture and decision
	// ****************************************
	logic [12:0] pkey [NCH];
	logic [NCH-1:0] below;
	logic [NCH-1:0] auto_on;
	logic [1:0] ion_ok;
	logic gauge_ok [2];

	// Ion channel gating against gauge state and inhibit switches
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			ion_ok[c] = ((ig_on[0] & ~inh[c*2]) | (ig_on[1] & ~inh[c*2+1]))
				& ~(ig_on[0] & inh[c*2]) & ~(ig_on[1] & inh[c*2+1]);
			gauge_ok[c] = ig_on[w_gauge] & ~inh[c*2 + int'(w_gauge)];
		end
	end

	// Latch the newest word per channel; setpoint shows freeze it, degas freezes only channels 1-2
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			for (int i = 0; i < NCH; i++) begin
				pkey[i] <= KEY_OVF;
			end
		end else if (word_new && ui == SRCTL_IDLE) begin
			for (int i = 0; i < NCH; i++) begin
				if (w_line == 2'(i / 2 + 1)) begin
					if (i >= 2 || (!degas && gauge_ok[i % 2])) begin
						pkey[i] <= w_key;
					end
				end
			end
		end
	end

	// Hysteresis latch: true while pressure sits below the setpoint
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			below <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (sp_mant[i] == MANT_ATM) begin
					below[i] <= (pkey[i] != KEY_OVF);
				end else if (sp_mant[i] == MANT_ZERO) begin
					below[i] <= 1'b0;
				end else if (!below[i] &&
						pkey[i] < key_of(sp_exp[i], 7'(sp_mant[i] * 4'd10))) begin
					below[i] <= 1'b1;
				end else if (below[i] && pkey[i] >= thr_of(sp_exp[i], sp_mant[i])) begin
					below[i] <= 1'b0;
				end
			end
		end
	end

	// Polarity then module gating; gating is after polarity on purpose
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			auto_on[i] = pol[i] ? ~below[i] : below[i];
		end
		auto_on[1:0] = auto_on[1:0] & ion_ok;
		auto_on[3:2] = auto_on[3:2] & {2{sec_a}};
		auto_on[5:4] = auto_on[5:4] & {2{sec_b}};
	end

	// Override beats automatic; indicators mirror the driven relay
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			RELAY_OUT <= '0;
			LED_OUT <= '0;
		end else begin
			RELAY_OUT <= frc_on | (~frc_off & auto_on);
			LED_OUT <= frc_on | (~frc_off & auto_on);
		end
	end

	// Status word for software
	always_comb begin
		status = '0;
		status[NCH-1:0] = RELAY_OUT;
		status[STAT_SHOW_BIT] = SP_SHOW_OUT;
		status[STAT_ADJ_BIT] = (ui == SRCTL_HELD);
		status[STAT_CH_LSB +: 3] = ui_ch;
	end
endmodule
`default_nettype wire

// ### rtl/srctl_pkg.sv
package srctl_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
	localparam int unsigned SHOW_MS = 2000;
	localparam int unsigned SLOW_MS = 400;
	localparam int unsigned FAST_MS = 40;
	localparam int unsigned SHOW_CYC = SHOW_MS * CLK_PER_MS;
	localparam int unsigned SLOW_CYC = SLOW_MS * CLK_PER_MS;
	localparam int unsigned FAST_CYC = FAST_MS * CLK_PER_MS;
	localparam int TMR_W = 28;
	localparam int NCH = 6;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_OVR = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_SP0 = 8'h10;
	localparam int CTRL_POL_LSB = 0;
	localparam int CTRL_INH_LSB = 8;
	localparam int OVR_ON_LSB = 0;
	localparam int OVR_OFF_LSB = 8;
	localparam int SP_EXP_LSB = 8;
	localparam int STAT_SHOW_BIT = 8;
	localparam int STAT_ADJ_BIT = 9;
	localparam int STAT_CH_LSB = 12;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] OVR_RST = 32'h0000_0000;
	// ****************************************
	// Setpoint encoding
	// ****************************************
	localparam logic [3:0] MANT_ZERO = 4'h0;
	localparam logic [3:0] MANT_MIN = 4'h1;
	localparam logic [3:0] MANT_MAX = 4'h9;
	localparam logic [3:0] MANT_ATM = 4'ha;
	localparam logic signed [5:0] EXP_MIN = -6'sd12;
	localparam logic signed [5:0] EXP_MAX = 6'sd5;
	localparam logic [3:0] SP_MANT_RST = 4'h0;
	localparam logic signed [5:0] SP_EXP_RST = 6'sd0;
	localparam int EXP_BIAS = 16;
	localparam logic [12:0] KEY_OVF = 13'h1fff;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {SRCTL_IDLE, SRCTL_HELD, SRCTL_SHOW} srctl_ui_t;
endpackage

// ### test/srctl_gauge_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Gauge module on the display bus
// ********
module srctl_gauge_model (
	// Clock
	input wire logic clk_in,
	// Display bus
	output logic stb_out,
	output logic [1:0] line_out,
	output logic gauge_out,
	output logic [3:0] d1_out,
	output logic [3:0] d2_out,
	output logic signed [5:0] exp_out,
	output logic ovf_out
);
	initial begin
		stb_out = 1'b0;
		{line_out, gauge_out, d1_out, d2_out, exp_out, ovf_out} = 18'h0;
	end
	// One word: data three clocks ahead of strobe, held five clocks after its rise
	task automatic send(input logic [1:0] ln, input logic g, input logic [3:0] a,
		input logic [3:0] b, input logic [5:0] e, input logic o);
		{line_out, gauge_out, d1_out, d2_out, exp_out, ovf_out} <= {ln, g, a, b, e, o};
		repeat (3) @(posedge clk_in);
		stb_out <= 1'b1;
		repeat (5) @(posedge clk_in);
		stb_out <= 1'b0;
		// Hold time over: inverted so nobody can lean on stale data
		{line_out, gauge_out, d1_out, d2_out, exp_out, ovf_out} <= ~{ln, g, a, b, e, o};
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ### test/srctl_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Relay controller checker
// ********
module srctl_top_sva
	import srctl_pkg::*;
#(
	parameter int unsigned SHOW_CYCLES = 50
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	// Bus
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [31:0] WB_DAT_IN,
	input wire logic WB_ACK_OUT,
	// Panel and gauges
	input wire logic UP_BTN_IN,
	input wire logic DOWN_BTN_IN,
	input wire logic [2:0] CHAN_SEL_IN,
	input wire logic FIRST_ION_GAUGE_ON_IN,
	input wire logic SECOND_ION_GAUGE_ON_IN,
	input wire logic SEC_A_PRESENT_IN,
	input wire logic SEC_B_PRESENT_IN,
	// Outputs
	input wire logic SP_SHOW_OUT,
	input wire logic [1:0] SP_LINE_OUT,
	input wire logic NVM_WR_OUT,
	input wire logic [srctl_pkg::NCH-1:0] RELAY_OUT,
	input wire logic [srctl_pkg::NCH-1:0] LED_OUT
);
	logic [5:0] ovr_on, ovr_off;
	logic [2:0] ovr_age;
	logic [31:0] idle_cnt;
	logic ovr_wr;
	assign ovr_wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT && WB_ADR_IN == ADR_OVR;
	// Override shadow; age says how long it has settled
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			ovr_on <= 6'h00;
			ovr_off <= 6'h00;
			ovr_age <= 3'h0;
		end else if (ovr_wr) begin
			ovr_on <= WB_DAT_IN[OVR_ON_LSB +: 6];
			ovr_off <= WB_DAT_IN[OVR_OFF_LSB +: 6];
			ovr_age <= 3'h0;
		end else if (ovr_age != 3'h7) begin
			ovr_age <= ovr_age + 3'h1;
		end
	end
	// Cycles since both buttons went up; raw pins, so sync lag is allowed for
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			idle_cnt <= 32'h0;
		end else if (UP_BTN_IN || DOWN_BTN_IN) begin
			idle_cnt <= 32'h0;
		end else if (idle_cnt != 32'hffff_ffff) begin
			idle_cnt <= idle_cnt + 32'h1;
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	a_ack_once: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
		else $error("bus ack missing or too long");
	a_led_match: assert property (LED_OUT == RELAY_OUT)
		else $error("indicator differs from relay");
	a_force_on: assert property (ovr_age == 3'h7 |-> (RELAY_OUT & ovr_on) == ovr_on)
		else $error("forced relay not on");
	a_force_off: assert property (ovr_age == 3'h7 |-> (RELAY_OUT & ovr_off & ~ovr_on) == 6'h00)
		else $error("forced relay not off");
	a_sec_a_off: assert property ((!SEC_A_PRESENT_IN && ovr_age == 3'h7) [*8] |->
		(RELAY_OUT[3:2] & ~ovr_on[3:2]) == 2'h0) else $error("channels 3-4 active without module");
	a_sec_b_off: assert property ((!SEC_B_PRESENT_IN && ovr_age == 3'h7) [*8] |->
		(RELAY_OUT[5:4] & ~ovr_on[5:4]) == 2'h0) else $error("channels 5-6 active without module");
	a_ion_off: assert property ((!FIRST_ION_GAUGE_ON_IN && !SECOND_ION_GAUGE_ON_IN
		&& ovr_age == 3'h7) [*8] |->
		(RELAY_OUT[1:0] & ~ovr_on[1:0]) == 2'h0) else $error("ion channel active, gauges off");
	a_show_line: assert property ($rose(SP_SHOW_OUT) |->
		SP_LINE_OUT == 2'(({1'b0, $past(CHAN_SEL_IN, 4)} + 4'h1) >> 1))
		else $error("setpoint on wrong line");
	a_show_time: assert property ($fell(SP_SHOW_OUT) |->
		idle_cnt >= SHOW_CYCLES && idle_cnt <= SHOW_CYCLES + 6) else $error("show time wrong");
	a_store_once: assert property (NVM_WR_OUT |-> idle_cnt >= SHOW_CYCLES ##1 !NVM_WR_OUT)
		else $error("store early or long");
	c_show: cover property ($rose(SP_SHOW_OUT));
	c_store: cover property (NVM_WR_OUT);
	c_relay: cover property ($rose(RELAY_OUT[2]));
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker attachment
// ********
bind srctl_top srctl_top_sva #(.SHOW_CYCLES(SHOW_CYCLES)) chk (.CLK_IN(CLK_IN),
	.SYS_RST_IN(SYS_RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN),
	.WB_ADR_IN(WB_ADR_IN), .WB_DAT_IN(WB_DAT_IN), .WB_ACK_OUT(WB_ACK_OUT), .UP_BTN_IN(UP_BTN_IN),
	.DOWN_BTN_IN(DOWN_BTN_IN), .CHAN_SEL_IN(CHAN_SEL_IN),
	.FIRST_ION_GAUGE_ON_IN(FIRST_ION_GAUGE_ON_IN), .SECOND_ION_GAUGE_ON_IN(SECOND_ION_GAUGE_ON_IN),
	.SEC_A_PRESENT_IN(SEC_A_PRESENT_IN), .SEC_B_PRESENT_IN(SEC_B_PRESENT_IN),
	.SP_SHOW_OUT(SP_SHOW_OUT), .SP_LINE_OUT(SP_LINE_OUT), .NVM_WR_OUT(NVM_WR_OUT),
	.RELAY_OUT(RELAY_OUT), .LED_OUT(LED_OUT));
// ********
// Bench top
// ********
module tb;
	import srctl_pkg::*;
	logic clk, rst, cyc, stb, we, up, dn, g1, g2, degas, sec_a, sec_b;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [2:0] chan, nvm_a;
	logic [31:0] wdat, rdat;
	logic [12:0] nvm_d;
	logic [20:0] rows [10];
	wire logic ack, show, nvm_wr, d_stb, d_g, d_ovf;
	wire logic [31:0] dout;
	wire logic [1:0] sp_line, d_line;
	wire logic [3:0] sp_mant, d1, d2;
	wire logic signed [5:0] sp_exp, d_exp;
	wire logic [2:0] nvm_aw;
	wire logic [12:0] nvm_dw;
	wire logic [5:0] relay;
	int n_errors = 0, comparisons = 0, nvm_cnt = 0, t;
	srctl_top #(.SHOW_CYCLES(50), .SLOW_CYCLES(8), .FAST_CYCLES(2)) DUT (.CLK_IN(clk),
		.SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
		.WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .UP_BTN_IN(up),
		.DOWN_BTN_IN(dn), .CHAN_SEL_IN(chan), .FIRST_ION_GAUGE_ON_IN(g1),
		.SECOND_ION_GAUGE_ON_IN(g2), .DEGAS_IN(degas), .SEC_A_PRESENT_IN(sec_a),
		.SEC_B_PRESENT_IN(sec_b), .DISP_STB_IN(d_stb), .DISP_LINE_IN(d_line), .DISP_GAUGE_IN(d_g),
		.DISP_D1_IN(d1), .DISP_D2_IN(d2), .DISP_EXP_IN(d_exp), .DISP_OVF_IN(d_ovf),
		.SP_SHOW_OUT(show), .SP_LINE_OUT(sp_line), .SP_MANT_OUT(sp_mant), .SP_EXP_OUT(sp_exp),
		.NVM_WR_OUT(nvm_wr), .NVM_ADDR_OUT(nvm_aw), .NVM_DATA_OUT(nvm_dw), .RELAY_OUT(relay),
		.LED_OUT());
	srctl_gauge_model gauge (.clk_in(clk), .stb_out(d_stb), .line_out(d_line), .gauge_out(d_g),
		.d1_out(d1), .d2_out(d2), .exp_out(d_exp), .ovf_out(d_ovf));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Store pulses are one cycle wide, so catch them here
	always @(posedge clk) begin
		if (nvm_wr === 1'b1) begin
			nvm_cnt++;
			nvm_a = nvm_aw;
			nvm_d = nvm_dw;
		end
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Classic single cycle; holds until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		rdat = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(rdat, e);
	endtask
	function automatic logic [31:0] spw(input logic [3:0] m, input logic [5:0] e);
		return {18'h0, e, 4'h0, m};
	endfunction
	task automatic word(input logic [1:0] l, input logic g, input logic [3:0] a,
		input logic [3:0] b, input logic [5:0] e, input logic o);
		gauge.send(l, g, a, b, e, o);
		tick(6);
	endtask
	task automatic tap(input logic v);
		t = 0;
		while (show !== v && t < 400) begin
			@(posedge clk);
			t++;
		end
		check(show, v);
	endtask
	// Watchdog, far beyond the expected run
	initial begin
		tick(20000);
		n_errors++;
		results();
	end
	initial begin
		{rst, cyc, stb, we, up, dn, degas, g1, g2, sec_a, sec_b} = 11'h40f;
		{adr, wdat, sel, chan} = {8'h0, 32'h0, 4'hf, 3'd3};
		// Rows: line, digits, exponent, overflow, expected relays 6..3
		rows = '{{2'd2, 8'h70, 6'h00, 1'b0, 4'h2}, {2'd3, 8'h50, 6'h02, 1'b0, 4'h6},
			{2'd2, 8'h60, 6'h00, 1'b0, 4'h6}, {2'd2, 8'h59, 6'h00, 1'b0, 4'h5},
			{2'd2, 8'h66, 6'h00, 1'b0, 4'h5}, {2'd2, 8'h67, 6'h00, 1'b0, 4'h6},
			{2'd3, 8'h99, 6'h09, 1'b1, 4'h2}, {2'd2, 8'h10, 6'h3d, 1'b0, 4'h1},
			{2'd3, 8'h10, 6'h34, 1'b0, 4'h5}, {2'd2, 8'h60, 6'h01, 1'b0, 4'h6}};
		tick(6);
		rst <= 1'b0;
		tick(1);
		rd(ADR_CTRL, CTRL_RST);
		rd(ADR_OVR, OVR_RST);
		rd(ADR_SP0, 32'h0);
		wb(1'b1, 8'h40, 32'h0000_0005);
		rd(8'h40, 32'h0);
		wb(1'b1, ADR_SP0, spw(4'h5, 6'h3a));
		wb(1'b1, ADR_SP0 + 8'h08, spw(4'h6, 6'h00));
		wb(1'b1, ADR_SP0 + 8'h0c, spw(4'h6, 6'h00));
		wb(1'b1, ADR_SP0 + 8'h10, spw(MANT_ATM, 6'h00));
		wb(1'b1, ADR_SP0 + 8'h14, spw(4'hb, 6'h00));
		rd(ADR_SP0 + 8'h14, 32'h0);
		rd(ADR_SP0 + 8'h08, spw(4'h6, 6'h00));
		wb(1'b1, ADR_CTRL, 32'h8);
		foreach (rows[i]) begin
			word(rows[i][20:19], 1'b0, rows[i][18:15], rows[i][14:11], rows[i][10:5], rows[i][4]);
			check(relay[5:2], rows[i][3:0]);
		end
		rd(ADR_STAT, 32'h18);
		sec_a <= 1'b0;
		sec_b <= 1'b0;
		tick(10);
		check(relay[5:2], 4'h0);
		sec_a <= 1'b1;
		sec_b <= 1'b1;
		word(2'd1, 1'b0, 4'h4, 4'h0, 6'h3a, 1'b0);
		check(relay[1:0], 2'b01);
		wb(1'b1, ADR_CTRL, 32'h108);
		tick(4);
		check(relay[1:0], 2'b00);
		wb(1'b1, ADR_CTRL, 32'h8);
		word(2'd1, 1'b0, 4'h4, 4'h0, 6'h3a, 1'b0);
		degas <= 1'b1;
		tick(4);
		word(2'd1, 1'b0, 4'h9, 4'h0, 6'h3a, 1'b0);
		check(relay[1:0], 2'b01);
		degas <= 1'b0;
		tick(4);
		word(2'd1, 1'b0, 4'h9, 4'h0, 6'h3a, 1'b0);
		check(relay[1:0], 2'b00);
		word(2'd1, 1'b0, 4'h4, 4'h0, 6'h3a, 1'b0);
		g1 <= 1'b0;
		g2 <= 1'b0;
		tick(10);
		check(relay[1:0], 2'b00);
		wb(1'b1, ADR_OVR, 32'h1022);
		tick(4);
		check({relay[5:4], relay[1]}, 3'b101);
		wb(1'b1, ADR_OVR, 32'h0);
		tick(4);
		check(relay[5:4], 2'b01);
		g1 <= 1'b1;
		g2 <= 1'b1;
		word(2'd2, 1'b0, 4'h6, 4'h0, 6'h01, 1'b0);
		up <= 1'b1;
		tick(3);
		up <= 1'b0;
		tap(1'b1);
		check({sp_line, sp_mant, sp_exp}, {2'd2, 4'h6, 6'h00});
		word(2'd2, 1'b0, 4'h1, 4'h0, 6'h3d, 1'b0);
		check(relay[3:2], 2'b10);
		tap(1'b0);
		check(nvm_cnt, 0);
		dn <= 1'b1;
		t = 0;
		while (sp_mant !== 4'h3 && t < 400) begin
			@(posedge clk);
			t++;
		end
		dn <= 1'b0;
		tap(1'b0);
		check({nvm_cnt[3:0], nvm_a, nvm_d}, {4'h1, 3'd2, 13'h0600});
		rd(ADR_SP0 + 8'h08, spw(4'h3, 6'h00));
		up <= 1'b1;
		tick(3);
		up <= 1'b0;
		tap(1'b1);
		chan <= 3'd5;
		tick(4);
		check(sp_line, 2'd2);
		tap(1'b0);
		tick(8);
		up <= 1'b1;
		tick(3);
		up <= 1'b0;
		tap(1'b1);
		check({sp_line, sp_mant}, {2'd3, MANT_ATM});
		tap(1'b0);
		check(nvm_cnt, 1);
		results();
	end
endmodule
`default_nettype wire
